// [include/iom_defines.vh]
`ifndef IOM_DEFINES_VH
`define IOM_DEFINES_VH
// Register indices on the plain register port.
`define IOM_ADDR_W 4
`define IOM_REG_LINE_DIR 4'h0
`define IOM_REG_LINE_OUT 4'h1
`define IOM_REG_LINE_PU 4'h2
`define IOM_REG_LINE_PD 4'h3
`define IOM_REG_LINE_IN 4'h4
`define IOM_REG_CTRL 4'h5
`define IOM_REG_MODE 4'h6
// Number of general lines handled (index 0..31).
`define IOM_NLINES 32
// Line numbers of the special lines.
`define IOM_LINE_OTA 7
`define IOM_LINE_TX 21
`define IOM_LINE_RX 22
`define IOM_LINE_RTS 23
`define IOM_LINE_CTS 24
`define IOM_LINE_AUTORUN 28
// Reset defaults: direction 1 = output.
`define IOM_DIR_RST 32'h00A00000
`define IOM_OUT_RST 32'h00200000
`define IOM_PU_RST 32'h624FFF7F
`define IOM_PD_RST 32'h01000080
// Lines that exist as general digital lines.
`define IOM_LINE_MASK 32'h63EFFFFF
// Edges counted after reset release before the straps are taken.
`define IOM_MODE_SETTLE 3'h6
// Control register bit positions.
`define IOM_CTRL_SERIAL_OPEN 0
`define IOM_CTRL_SCRIPT_STORED 1
`define IOM_CTRL_MODE_RESAMPLE 2
// Mode codes.
`define IOM_MODE_COMMAND 2'h0
`define IOM_MODE_AUTORUN 2'h1
`define IOM_MODE_BRIDGE 2'h2
`define IOM_MODE_DEV 2'h3
`endif

// [rtl/iom_sync3.v]
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; output moves when stages two and three agree.
module iom_sync3
(
   input wire sys_clk_i,
   input wire rst_i,
   input wire pin_i,
   output reg level_o
);
   reg s1;
   reg s2;
   reg s3;
   // Shift the pin through three flip-flops and filter on the last two.
   always @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         level_o <= 1'b0;
      end
      else
      begin
         s1 <= pin_i;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            level_o <= s3;
      end
   end
endmodule // iom_sync3
`default_nettype wire

// [rtl/iom_mode_sel.v]
`timescale 1ns/1ps
`default_nettype none
`include "iom_defines.vh"
// Captures the straps after reset release and decides the operating mode.
module iom_mode_sel
(
   input wire sys_clk_i,
   input wire rst_i,
   input wire resample_i,
   input wire ota_sel_i,
   input wire autorun_select_n_i,
   input wire script_stored_i,
   output reg [1:0] mode_o,
   output reg ota_dl_en_o,
   output reg mode_valid_o
);
   // Straps are caught once the synchronisers have settled.
   reg [2:0] settle;
   reg [1:0] next_mode;
   always @*
   begin
      // R7: bridge mode
      if (ota_sel_i && autorun_select_n_i)
         next_mode = `IOM_MODE_BRIDGE;
      // R9: autorun start
      else if (!autorun_select_n_i && script_stored_i)
         next_mode = `IOM_MODE_AUTORUN;
      // R12: command default
      else if (!script_stored_i)
         next_mode = `IOM_MODE_COMMAND;
      // R10: development mode
      else
         next_mode = `IOM_MODE_DEV;
   end
   // Hold the decision until the next reset or resample request.
   always @(posedge sys_clk_i)
   begin
      if (rst_i || resample_i)
      begin
         settle <= 3'h0;
         mode_valid_o <= 1'b0;
         mode_o <= `IOM_MODE_COMMAND;
         ota_dl_en_o <= 1'b0;
      end
      else if (settle != `IOM_MODE_SETTLE)
         settle <= settle + 3'h1;
      else if (!mode_valid_o)
      begin
         // R20: sample synchronised straps
         mode_o <= next_mode;
         // R6: download when high
         ota_dl_en_o <= ota_sel_i;
         mode_valid_o <= 1'b1;
      end
   end
endmodule // iom_mode_sel
`default_nettype wire

// [rtl/iom_io_default.v]
`timescale 1ns/1ps
`default_nettype none
`include "iom_defines.vh"
// Function
// R1: Reset restores every line's default function, direction and pull.
// R2: Transmit-capable line defaults to output driven high.
// R3: Request-to-send line defaults to output driven low.
// R4: Receive-capable line defaults to input with pull-up.
// R5: Clear-to-send line defaults to input with pull-down.
// R6: Over-the-air select defaults input pull-down; high enables download.
// R7: Both straps high bridges serial to wireless service, commands stop.
// R8: Outside party holds external reset low at least 100 ms.
// R9: Autorun select low plus stored script starts script at reset.
// R10: Autorun select at ground is run mode, at supply is development.
// R11: Autorun select has no pull; outside party must drive it.
// R12: Without stored script the device starts in command mode.
// R13: Pull settings refused on lines with an alternate function active.
// R14: Handshake lines are asserted at low level.
// R15: Serial data lines idle high.
// R16: Default inputs start with pull-up; software may disable it.
// R17: Opening serial switches four lines; closing returns general function.
// R18: Autorun script keeps four serial lines general until opened.
// R19: Controller makes its own chip select from a spare line.
// R20: Straps pass a synchroniser before sampling after reset.
module iom_io_default
(
   input wire sys_clk_i,
   input wire rst_i,
   input wire [3:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   input wire [31:0] line_in_i,
   output wire [31:0] line_out_o,
   output wire [31:0] line_oe_o,
   output wire [31:0] line_pu_o,
   output wire [31:0] line_pd_o,
   input wire ser_tx_i,
   input wire ser_rts_n_i,
   output reg ser_rx_o,
   output reg ser_cts_n_o,
   output wire serial_active_o,
   output wire [1:0] mode_o,
   output wire mode_valid_o,
   output wire ota_dl_en_o,
   output wire bridge_o
);
   // Software-visible configuration.
   reg [31:0] dir;
   reg [31:0] dout;
   reg [31:0] pu;
   reg [31:0] pd;
   reg serial_open;
   reg script_stored;
   reg resample;
   wire [31:0] sync_in;
   wire [31:0] alt_mask;
   wire [31:0] pu_w;
   wire [31:0] pd_w;
   wire [31:0] eff_dir;
   wire [31:0] eff_out;
   wire [31:0] ctrl_rd;

   // Returns a mask with one bit set for each of the four serial-capable lines.
   function [31:0] iom_serial_mask;
      input dummy;
      begin
         iom_serial_mask = 32'h0;
         iom_serial_mask[`IOM_LINE_TX] = 1'b1;
         iom_serial_mask[`IOM_LINE_RX] = 1'b1;
         iom_serial_mask[`IOM_LINE_RTS] = 1'b1;
         iom_serial_mask[`IOM_LINE_CTS] = 1'b1;
      end
   endfunction

   // Every input line passes its own synchroniser.
   genvar g;
   generate
      for (g = 0; g < `IOM_NLINES; g = g + 1)
      begin : g_sync
         iom_sync3 u_sync
         (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .pin_i(line_in_i[g]),
            .level_o(sync_in[g])
         );
      end
   endgenerate

   // R17: serial function select
   assign alt_mask = serial_open ? iom_serial_mask(1'b0) : 32'h0;
   assign serial_active_o = serial_open;

   // Mode decision from synchronised straps.
   iom_mode_sel u_mode
   (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .resample_i(resample),
      .ota_sel_i(sync_in[`IOM_LINE_OTA]),
      .autorun_select_n_i(sync_in[`IOM_LINE_AUTORUN]),
      .script_stored_i(script_stored),
      .mode_o(mode_o),
      .ota_dl_en_o(ota_dl_en_o),
      .mode_valid_o(mode_valid_o)
   );
   assign bridge_o = mode_valid_o && (mode_o == `IOM_MODE_BRIDGE);

   // R13: refuse pull writes
   assign pu_w = (pu & alt_mask) | (wdata_i & ~alt_mask & `IOM_LINE_MASK);
   assign pd_w = (pd & alt_mask) | (wdata_i & ~alt_mask & `IOM_LINE_MASK);

   // Register writes; reset restores all defaults.
   always @(posedge sys_clk_i)
   begin
      // R1: restore defaults
      if (rst_i)
      begin
         // R2: tx out high
         // R3: rts out low
         dir <= `IOM_DIR_RST;
         dout <= `IOM_OUT_RST;
         // R4: rx pull-up
         // R5: cts pull-down
         // R16: input pull-ups
         pu <= `IOM_PU_RST;
         pd <= `IOM_PD_RST;
         // R18: serial stays closed
         serial_open <= 1'b0;
         script_stored <= 1'b0;
         resample <= 1'b0;
      end
      else
      begin
         resample <= wr_i && (addr_i == `IOM_REG_CTRL) && wdata_i[`IOM_CTRL_MODE_RESAMPLE];
         if (wr_i)
         begin
            case (addr_i)
               `IOM_REG_LINE_DIR: dir <= wdata_i & `IOM_LINE_MASK & ~(32'h1 << `IOM_LINE_AUTORUN);
               `IOM_REG_LINE_OUT: dout <= wdata_i & `IOM_LINE_MASK;
               `IOM_REG_LINE_PU: pu <= pu_w;
               `IOM_REG_LINE_PD: pd <= pd_w;
               `IOM_REG_CTRL:
               begin
                  serial_open <= wdata_i[`IOM_CTRL_SERIAL_OPEN];
                  script_stored <= wdata_i[`IOM_CTRL_SCRIPT_STORED];
               end
               default: ;
            endcase
         end
      end
   end

   // While serial is open the tx and rts lines are driven by the port.
   assign eff_dir = (dir & ~alt_mask) | (alt_mask & ((32'h1 << `IOM_LINE_TX) |
                    (32'h1 << `IOM_LINE_RTS)));
   // R15: tx idles high
   // R14: rts active low
   assign eff_out = (dout & ~alt_mask) |
                    (serial_open ? (({31'h0, ser_tx_i} << `IOM_LINE_TX) |
                    ({31'h0, ser_rts_n_i} << `IOM_LINE_RTS)) : 32'h0);
   assign line_oe_o = eff_dir;
   assign line_out_o = eff_out;
   // Pulls are released on lines given to the serial port.
   assign line_pu_o = pu & ~alt_mask & ~eff_dir;
   assign line_pd_o = pd & ~alt_mask & ~eff_dir;

   // Serial receive and clear-to-send; idle when closed.
   always @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         ser_rx_o <= 1'b1;
         ser_cts_n_o <= 1'b1;
      end
      else
      begin
         // R15: rx idles high
         ser_rx_o <= serial_open ? sync_in[`IOM_LINE_RX] : 1'b1;
         // R14: cts active low
         ser_cts_n_o <= serial_open ? sync_in[`IOM_LINE_CTS] : 1'b1;
      end
   end

   assign ctrl_rd = {29'h0, 1'b0, script_stored, serial_open};

   // Read data stand in the cycle after the read strobe.
   always @(posedge sys_clk_i)
   begin
      if (rst_i)
         rdata_o <= 32'h0;
      else if (rd_i)
      begin
         case (addr_i)
            `IOM_REG_LINE_DIR: rdata_o <= dir;
            `IOM_REG_LINE_OUT: rdata_o <= dout;
            `IOM_REG_LINE_PU: rdata_o <= pu;
            `IOM_REG_LINE_PD: rdata_o <= pd;
            `IOM_REG_LINE_IN: rdata_o <= sync_in & `IOM_LINE_MASK;
            `IOM_REG_CTRL: rdata_o <= ctrl_rd;
            `IOM_REG_MODE: rdata_o <= {28'h0, ota_dl_en_o, mode_valid_o, mode_o};
            default: rdata_o <= 32'h0;
         endcase
      end
      else
         rdata_o <= 32'h0;
   end
endmodule // iom_io_default
`default_nettype wire

// [test/iom_io_default_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the pad-facing outputs of the line default block.
module iom_io_default_monitor
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic ser_tx_i,
   input wire logic ser_rts_n_i,
   input wire logic ser_rx_o,
   input wire logic ser_cts_n_o,
   input wire logic [31:0] line_out_o,
   input wire logic [31:0] line_oe_o,
   input wire logic [31:0] line_pu_o,
   input wire logic [31:0] line_pd_o,
   input wire logic serial_active_o,
   input wire logic [1:0] mode_o,
   input wire logic mode_valid_o,
   input wire logic bridge_o,
   input wire logic ota_dl_en_o
);
   // One clock domain; checks pause while reset is high.
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // First cycle after reset is released.
   sequence s_rel;
      $fell(rst_i);
   endsequence
   // Software writes one to the serial open bit.
   sequence s_open;
      wr_i && addr_i == 4'h5 && wdata_i[0];
   endsequence
   // Serial port closed for at least two sampled edges.
   sequence s_closed;
      !serial_active_o && !$past(serial_active_o);
   endsequence
   a_dir_default: assert property (s_rel |-> line_oe_o == 32'h00A00000)
      else $error("default directions wrong");
   a_tx_high: assert property (s_rel |-> line_out_o[21])
      else $error("tx line not high");
   a_rts_low: assert property (s_rel |-> !line_out_o[23])
      else $error("rts line not low");
   a_rx_pullup: assert property (s_rel |-> line_pu_o[22] && !line_pd_o[22])
      else $error("rx line pull wrong");
   a_cts_pulldown: assert property (s_rel |-> line_pd_o[24] && !line_pu_o[24])
      else $error("cts line pull wrong");
   a_ota_pulldown: assert property (s_rel |-> line_pd_o[7] && !line_oe_o[7])
      else $error("ota line default wrong");
   a_cmd_start: assert property (s_rel |-> mode_o == 2'h0 && !mode_valid_o)
      else $error("mode not command after reset");
   a_open_lines: assert property (s_open |=> serial_active_o && line_oe_o[21])
      else $error("serial open did not switch lines");
   a_tx_follow: assert property (serial_active_o |-> line_out_o[21] == ser_tx_i)
      else $error("tx line does not follow port");
   a_no_pull_open: assert property (serial_active_o |-> line_pu_o[24:21] == 4'h0)
      else $error("pull on open serial line");
   a_bridge_mode: assert property (bridge_o |-> mode_valid_o && ota_dl_en_o)
      else $error("bridge without download strap");
   a_rts_follow: assert property (serial_active_o |-> line_out_o[23] == ser_rts_n_i)
      else $error("rts line does not follow port");
   a_rx_idle: assert property (s_closed |-> ser_rx_o && ser_cts_n_o)
      else $error("serial inputs not idle while closed");
endmodule // iom_io_default_monitor
bind iom_io_default iom_io_default_monitor u_mon
(
   .sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .ser_tx_i, .ser_rts_n_i, .ser_rx_o,
   .ser_cts_n_o, .line_out_o, .line_oe_o, .line_pu_o, .line_pd_o, .serial_active_o,
   .mode_o, .mode_valid_o, .bridge_o, .ota_dl_en_o
);
`default_nettype wire

// [test/iom_host_board.sv]
`timescale 1ns/1ps
`default_nettype none
// Board model: settles each pad from module drive, host drive and pulls.
module iom_host_board
(
   input wire logic sys_clk_i,
   input wire logic [31:0] line_out_i,
   input wire logic [31:0] line_oe_i,
   input wire logic [31:0] line_pu_i,
   input wire logic [31:0] line_pd_i,
   input wire logic [31:0] host_en_i,
   input wire logic [31:0] host_val_i,
   output logic [31:0] pad_o
);
   logic [31:0] flip = 32'h00000000;
   // Floating pads toggle so a stale level never looks valid.
   always @(posedge sys_clk_i) flip <= ~flip;
   // host drives straps and idles rx high.
   always_comb
      for (int i = 0; i < 32; i++)
         pad_o[i] = line_oe_i[i] ? line_out_i[i] : host_en_i[i] ? host_val_i[i] :
                    line_pu_i[i] ? 1'b1 : line_pd_i[i] ? 1'b0 : flip[i];
endmodule // iom_host_board
`default_nettype wire

// [test/test_iom_io_default.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_iom_io_default;
   logic sys_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, ser_tx_i = 1, ser_rts_n_i = 1;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0, host_en = 32'h11400000, host_val = 32'h10400000, pad;
   logic [4:0] mcase [4] = '{5'h0F, 5'h05, 5'h1E, 5'h00};
   wire [31:0] rdata_o, line_out_o, line_oe_o, line_pu_o, line_pd_o;
   wire ser_rx_o, ser_cts_n_o, serial_active_o, mode_valid_o, ota_dl_en_o, bridge_o;
   wire [1:0] mode_o;
   int n_fail = 0, cmp_count = 0;
   // Design and board; the host holds clear-to-send asserted low.
   iom_io_default DUT (.sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .line_in_i(pad), .line_out_o, .line_oe_o, .line_pu_o, .line_pd_o, .ser_tx_i,
      .ser_rts_n_i, .ser_rx_o, .ser_cts_n_o, .serial_active_o, .mode_o,
      .mode_valid_o, .ota_dl_en_o, .bridge_o);
   iom_host_board u_board (.sys_clk_i, .line_out_i(line_out_o), .line_oe_i(line_oe_o),
      .line_pu_i(line_pu_o), .line_pd_i(line_pd_o), .host_en_i(host_en),
      .host_val_i(host_val), .pad_o(pad));
   // A 100 ns clock.
   initial
      forever #50 sys_clk_i = ~sys_clk_i;
   // One-cycle register write.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1;
      @(posedge sys_clk_i);
      wr_i <= 0;
   endtask
   // Read strobe, then compare the data standing in the next cycle.
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1;
      @(posedge sys_clk_i);
      rd_i <= 0;
      #1 `CHK(rdata_o, e)
   endtask
   // host reset hold, cycles stand in for the long span.
   task automatic reset();
      @(posedge sys_clk_i);
      rst_i <= 1;
      repeat (10) @(posedge sys_clk_i);
      rst_i <= 0;
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Cuts a hang short.
   initial
   begin
      repeat (3000) @(posedge sys_clk_i);
      n_fail++;
      finish_test();
   end
   // Test sequence.
   initial
   begin
      reset();
      #1 `CHK(line_oe_o, 32'h00A00000)
      `CHK(line_out_o & 32'h00A00000, 32'h00200000)
      `CHK(line_pu_o & 32'h01EFFFFF, 32'h004FFF7F)
      `CHK(line_pd_o & 32'h01EFFFFF, 32'h01000080)
      wr(4'h0, 32'h10A00001);
      #1 `CHK(line_oe_o, 32'h00A00001)
      rd(4'h0, 32'h00A00001);
      rd(4'hF, 32'h0);
      reset();
      #1 `CHK(line_oe_o, 32'h00A00000)
      repeat (4) @(posedge sys_clk_i);
      rd(4'h4, 32'h626FFF7F);
      $display("defaults test done");
      foreach (mcase[k])
      begin
         host_en[7] <= mcase[k][4];
         host_val[7] <= mcase[k][4];
         host_val[28] <= mcase[k][3];
         repeat (6) @(posedge sys_clk_i);
         wr(4'h5, {29'h0, 1'b1, mcase[k][2], 1'b0});
         repeat (12) @(posedge sys_clk_i);
         rd(4'h6, {28'h0, mcase[k][4], 1'b1, mcase[k][1:0]});
         `CHK(ota_dl_en_o, mcase[k][4])
         `CHK(bridge_o, mcase[k][1:0] == 2'h2)
      end
      host_en[7] <= 0;
      host_val[28] <= 1;
      $display("mode test done");
      wr(4'h5, 32'h1);
      ser_tx_i <= 0;
      ser_rts_n_i <= 0;
      @(posedge sys_clk_i);
      #1 `CHK(line_out_o[21], 1'b0)
      `CHK(line_out_o[23], 1'b0)
      `CHK(serial_active_o, 1'b1)
      wr(4'h2, 32'h0);
      repeat (6) @(posedge sys_clk_i);
      #1 `CHK(ser_rx_o, 1'b1)
      `CHK(ser_cts_n_o, 1'b0)
      host_val[22] <= 0;
      repeat (6) @(posedge sys_clk_i);
      #1 `CHK(ser_rx_o, 1'b0)
      host_val[22] <= 1;
      ser_tx_i <= 1;
      ser_rts_n_i <= 1;
      wr(4'h5, 32'h0);
      #1 `CHK(line_oe_o, 32'h00A00000)
      `CHK(line_pu_o[22], 1'b1)
      `CHK(line_pu_o[0], 1'b0)
      wr(4'h0, 32'h00A00020);
      wr(4'h1, 32'h00200020);
      #1 `CHK(line_out_o[5], 1'b1)
      wr(4'h1, 32'h00200000);
      #1 `CHK(line_out_o[5] | line_pu_o[5], 1'b0)
      `CHK(line_out_o[21], 1'b1)
      $display("serial test done");
      finish_test();
   end
endmodule // test_iom_io_default
`default_nettype wire
